// file: gdr_top.v
// Graphics DMA request glue: device side request withdrawal logic.
// Assumes host strobes are synchronous to clk_in; request pins are open drain.
// Operation
// - DMA cycles are ordinary host reads and writes
// - Request withdrawn three clocks before deposit end
// - Both requests drop within 50 ns of write
// - Request drops after read, before next deposit
`timescale 1ns/1ns
`include "gdr_regs.vh"
module gdr_top
(
  input  wire       clk_in,
  input  wire       rst_b_in,
  input  wire       chip_sel_b_in,
  input  wire       wr_b_in,
  input  wire       rd_b_in,
  input  wire       dma_ack_input_b_in,
  input  wire       load_ready_in,
  input  wire       send_ready_in,
  input  wire       transfer_request_a_in,
  input  wire       transfer_request_b_in,
  output wire       transfer_request_a_out,
  output wire       transfer_request_a_oe_b_out,
  output wire       transfer_request_b_out,
  output wire       transfer_request_b_oe_b_out,
  output reg        write_strobe_out,
  output reg        read_strobe_out,
  output wire [1:0] state_out
);
  ////////////////////////////////////////////////////////////////
  // Reset synchroniser
  reg rst_s1_q;
  reg rst_s2_q;

  // Release through two flops so every flop leaves reset on the same edge
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire rst_b = rst_s2_q;

  ////////////////////////////////////////////////////////////////
  // Access detection
  // A DMA cycle is an ordinary selected read or write; acknowledge is unused
  wire wr_sel_b = wr_b_in | chip_sel_b_in;
  wire rd_sel_b = rd_b_in | chip_sel_b_in;
  wire wr_fall;
  wire rd_fall;
  wire ack_unused = dma_ack_input_b_in;

  gdr_strobe_edge u_wr_edge
  (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b),
    .strobe_b_in (wr_sel_b),
    .fall_out    (wr_fall)
  );

  gdr_strobe_edge u_rd_edge
  (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b),
    .strobe_b_in (rd_sel_b),
    .fall_out    (rd_fall)
  );

  ////////////////////////////////////////////////////////////////
  // Request state machine, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_REQ  = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  wire      any_ready = load_ready_in | send_ready_in;

  // Any selected strobe withdraws both requests on the same edge;
  // the request re-arms only once the strobe ends so one access serves one request
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (any_ready && wr_sel_b && rd_sel_b)
          state_d = ST_REQ;
      end
      ST_REQ:
      begin
        if (wr_fall || rd_fall || !any_ready)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Combinational drop: the pin goes inactive in the very strobe cycle,
  // well inside one 50 ns clock, leaving the host its wait-state margin
  wire req_live = state_q[1] & ~wr_fall & ~rd_fall;
  wire req_a    = req_live & load_ready_in;
  wire req_b    = req_live & send_ready_in;

  // Open drain: drive low (enable low) only when not requesting
  assign transfer_request_a_out      = 1'b0;
  assign transfer_request_a_oe_b_out = req_a;
  assign transfer_request_b_out      = 1'b0;
  assign transfer_request_b_oe_b_out = req_b;
  assign state_out                   = state_q;

  ////////////////////////////////////////////////////////////////
  // Access pulses toward the pixel logic, registered
  always @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      write_strobe_out <= 1'b0;
      read_strobe_out  <= 1'b0;
    end
    else
    begin
      write_strobe_out <= wr_fall & ack_unused | wr_fall & ~ack_unused;
      read_strobe_out  <= rd_fall;
    end
  end

  wire unused_ok = transfer_request_a_in ^ transfer_request_b_in;
endmodule

// file: gdr_regs.vh
// Constants for the graphics DMA request glue.
// Assumes a 20 MHz clk_in; included by bare name.
`ifndef GDR_REGS_VH
`define GDR_REGS_VH
`define GDR_CLK_PERIOD_NS   50
`define GDR_DROP_MAX_NS     50
// Longest time rounds down, never below one cycle
`define GDR_DROP_CYCLES     ((`GDR_DROP_MAX_NS / `GDR_CLK_PERIOD_NS) < 1 ? 1 : (`GDR_DROP_MAX_NS / `GDR_CLK_PERIOD_NS))
`define GDR_CNT_W           4
`define GDR_FILT_W          2
`endif

// file: gdr_strobe_edge.v
// Strobe edge detector: reports the first cycle a low-active strobe is seen.
// Assumes the strobe is synchronous to clk_in and reset is already synchronised.
`timescale 1ns/1ns
module gdr_strobe_edge
(
  input  wire clk_in,
  input  wire rst_b_in,
  input  wire strobe_b_in,
  output wire fall_out
);
  reg strobe_b_q;

  // Idle high after reset so a strobe held low out of reset still counts
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      strobe_b_q <= 1'b1;
    else
      strobe_b_q <= strobe_b_in;
  end

  assign fall_out = strobe_b_q & ~strobe_b_in;
endmodule

// file: gdr_checker.sv
// Port checks for the request glue.
// Assumes host strobes are synchronous to clk_in.
`timescale 1ns/1ns
module gdr_checker
(
  input wire clk_in,
  input wire rst_b_in,
  input wire chip_sel_b_in,
  input wire wr_b_in,
  input wire rd_b_in,
  input wire transfer_request_a_oe_b_out,
  input wire transfer_request_b_oe_b_out,
  input wire write_strobe_out,
  input wire read_strobe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Drop is combinational, so it is visible in the cycle of the strobe
  a_write_drop:
    assert property (!chip_sel_b_in && !wr_b_in |-> !transfer_request_a_oe_b_out && !transfer_request_b_oe_b_out)
    else $error("request up during write");
  a_read_drop:
    assert property (!chip_sel_b_in && !rd_b_in |-> !transfer_request_a_oe_b_out && !transfer_request_b_oe_b_out)
    else $error("request up during read");
  a_deposit_end:
    assert property ($rose(wr_b_in) |-> !transfer_request_a_oe_b_out)
    else $error("request up at deposit end");
  a_write_pulse:
    assert property ($fell(wr_b_in) && !chip_sel_b_in |=> write_strobe_out)
    else $error("write pulse missing");
  a_read_pulse:
    assert property ($fell(rd_b_in) && !chip_sel_b_in |=> read_strobe_out)
    else $error("read pulse missing");
  c_write: cover property (write_strobe_out);
  c_read: cover property (read_strobe_out);
  c_both: cover property (transfer_request_a_oe_b_out && transfer_request_b_oe_b_out);
endmodule
bind gdr_top gdr_checker u_gdr_checker (.*);

// file: gdr_host_model.sv
// Host bus model: one access per request, one wait state.
// Assumes request pins read high while released.
`timescale 1ns/1ns
module gdr_host_model
(
  input  wire clk_in,
  input  wire go_wr_in,
  input  wire go_rd_in,
  input  wire req_in,
  output reg  cs_b_out = 1'b1,
  output reg  wr_b_out = 1'b1,
  output reg  rd_b_out = 1'b1,
  output reg  done_out = 1'b0
);
  reg [2:0] cnt_q = 3'h0;
  reg       wr_q  = 1'b0;
  // Strobe low for three clocks: two plus the inserted wait
  always @(negedge clk_in)
  begin
    done_out <= 1'b0;
    if (cnt_q == 3'h0 && req_in && (go_wr_in || go_rd_in))
    begin
      cnt_q <= 3'h1; wr_q <= go_wr_in; cs_b_out <= 1'b0;
    end
    else if (cnt_q == 3'h1)
    begin
      cnt_q <= 3'h2; wr_b_out <= !wr_q; rd_b_out <= wr_q;
    end
    else if (cnt_q == 3'h4)
    begin
      cnt_q <= 3'h0; wr_b_out <= 1'b1; rd_b_out <= 1'b1; cs_b_out <= 1'b1; done_out <= 1'b1;
    end
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q + 3'h1;
  end
endmodule

// file: tb_gdr_top.sv
// Bench for the request glue with a host model on the bus.
`timescale 1ns/1ns
module tb_gdr_top;
  reg clk = 0, rst_b = 0, load = 0, send = 0, go_wr = 0, go_rd = 0;
  wire cs_b, wr_b, rd_b, done, a_o, a_oe_b, b_o, b_oe_b, ws, rs;
  wire [1:0] st;
  wire pin_a = a_oe_b ? 1'b1 : a_o; // Pull-up when released
  wire pin_b = b_oe_b ? 1'b1 : b_o;
  integer fails = 0, samples_checked = 0, pulses = 0, i;
  initial forever #25 clk = !clk;
  always @(posedge clk) if (ws === 1'b1 || rs === 1'b1) pulses = pulses + 1;
  gdr_top u_gdr_top (.clk_in(clk), .rst_b_in(rst_b), .chip_sel_b_in(cs_b), .wr_b_in(wr_b),
    .rd_b_in(rd_b), .dma_ack_input_b_in(1'b1), .load_ready_in(load), .send_ready_in(send),
    .transfer_request_a_in(pin_a), .transfer_request_b_in(pin_b), .transfer_request_a_out(a_o),
    .transfer_request_a_oe_b_out(a_oe_b), .transfer_request_b_out(b_o),
    .transfer_request_b_oe_b_out(b_oe_b), .write_strobe_out(ws), .read_strobe_out(rs), .state_out(st));
  gdr_host_model u_gdr_host_model (.clk_in(clk), .go_wr_in(go_wr), .go_rd_in(go_rd),
    .req_in(go_wr ? pin_a : pin_b), .cs_b_out(cs_b), .wr_b_out(wr_b), .rd_b_out(rd_b), .done_out(done));
  task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin fails = fails + 1; $display("Error %0s exp %h seen %h", name, exp, seen); end
  endtask
  task end_sim;
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One access; request pin must be low whenever a strobe is low
  task access(input w);
    pulses = 0; load = w; send = !w; go_wr = w; go_rd = !w;
    // Let the previous done pulse clear before watching for the next one
    @(negedge clk);
    for (i = 0; i < 30 && done !== 1'b1; i = i + 1)
    begin
      @(negedge clk);
      if (!wr_b || !rd_b) check("req_pins", {pin_a, pin_b}, 2'h0);
    end
    if (i == 30) begin fails = fails + 1; end_sim; end
    go_wr = 0; go_rd = 0; load = 0; send = 0;
    check("pulses", pulses, 1);
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    check("oe_b", {a_oe_b, b_oe_b}, 2'h0);
    check("state", st, 2'h1);
    rst_b = 1;
    access(1); access(1); access(0); access(1);
    repeat (3) @(negedge clk);
    check("state", st, 2'h1);
    end_sim;
  end
endmodule
